// ### core/pdm_pkg.sv
// ============================================================
// Power-down control constants
package pdm_pkg;

   // ============================================================
   // Register indices (byte address is four times the index)
   localparam logic [31:0] IDX_STBY = 32'hFFFF1004;
   localparam int          N_REG16  = 7;
   localparam int          N_HALT   = 2;
   localparam int          DIV5_POS = 6;
   localparam logic [31:0] REG16_IDX [0:N_REG16-1] = '{
      32'hFFFF1030, 32'hFFFF1032, 32'hFFFF1034, 32'hFFFF1036,
      32'hFFFF1038, 32'hFFFF103A, 32'hFFFF103C
   };
   localparam logic [2:0]  SEL_STBY = 3'h7;

   // ============================================================
   // Standby control fields and reset values
   localparam int          SBY_BIT     = 7;
   localparam int          HIZ_BIT     = 6;
   localparam logic [7:0]  STBY_RST    = 8'h1F;
   localparam logic [5:0]  STBY_FIXED  = 6'h1F;
   localparam logic [15:0] HALT_RST    = 16'h0000;
   localparam logic [15:0] DIV_FAST    = 16'h8888;
   localparam logic [15:0] DIV5_FAST   = 16'hCCCC;
   localparam logic [15:0] DIV_SLOW    = 16'hFFFF;
   localparam logic [15:0] DIV_RO      = 16'h8888;
   localparam logic [7:0]  FAST_MODES  = 8'h6A;

   // ============================================================
   // Module clock layout
   localparam int          REG_W    = 16;
   localparam int          N_MOD    = 32;
   localparam int          N_FIELDS = 20;
   localparam int          FIELD_W  = 3;
   localparam int          NIB_W    = 4;
   localparam int          NIB_PER  = 4;
   localparam int          CNT_W    = 8;

   // ============================================================
   // Bus encodings
   localparam logic [2:0]  HSIZE_WORD = 3'h2;
   localparam logic        HRESP_OKAY = 1'h0;

   // ============================================================
   // Power states
   typedef enum logic [1:0] {
      PDM_RUN,
      PDM_SLEEP,
      PDM_SW_STBY,
      PDM_HW_STBY
   } pdm_state_t;

endpackage

// ### core/pdm_clk_if.sv
`timescale 1ns/1ps
// ============================================================
// Module clock control bundle
interface pdm_clk_if;
   logic [pdm_pkg::N_MOD-1:0]                  halt_bits;
   logic [pdm_pkg::N_FIELDS*pdm_pkg::FIELD_W-1:0] div_fields;
   logic                                       stop_all;
   logic [pdm_pkg::N_MOD-1:0]                  mod_clk_en;
   logic [pdm_pkg::N_FIELDS-1:0]               div_tick;

   modport ctl  (output halt_bits, div_fields, stop_all, input mod_clk_en, div_tick);
   modport gate (input halt_bits, div_fields, stop_all, output mod_clk_en, div_tick);
endinterface

// ### core/pdm_clk_gate.sv
`timescale 1ns/1ps
// ============================================================
// Module clock enables and divided ticks
module pdm_clk_gate (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Control bundle
   pdm_clk_if.gate   cg
);

   logic [pdm_pkg::CNT_W-1:0]    cnt_reg;
   logic [pdm_pkg::N_MOD-1:0]    en_reg;
   logic [pdm_pkg::N_MOD-1:0]    en_next;
   logic [pdm_pkg::N_FIELDS-1:0] tick_reg;
   logic [pdm_pkg::N_FIELDS-1:0] tick_next;

   // Mask of low counter bits for a ratio field
   function automatic logic [pdm_pkg::CNT_W-1:0] div_mask(input logic [2:0] f);
      return pdm_pkg::CNT_W'((1 << f) - 1);
   endfunction

   // Free counter, frozen while clocks are stopped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= '0;
      end else if (!cg.stop_all) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   assign en_next = ~cg.halt_bits & {pdm_pkg::N_MOD{~cg.stop_all}};

   for (genvar j = 0; j < pdm_pkg::N_FIELDS; j++) begin : g_tick
      assign tick_next[j] = ~cg.stop_all &
         ((cnt_reg & div_mask(cg.div_fields[j*pdm_pkg::FIELD_W +: pdm_pkg::FIELD_W])) == '0);
   end

   // Registered outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_reg   <= '1;
         tick_reg <= '0;
      end else begin
         en_reg   <= en_next;
         tick_reg <= tick_next;
      end
   end

   assign cg.mod_clk_en = en_reg;
   assign cg.div_tick   = tick_reg;

   // Checks
   a_halt_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      !cg.stop_all |=> cg.mod_clk_en == ~$past(cg.halt_bits))
      else $error("module enable does not follow halt bits");
   a_div_ratio: assert property (@(posedge hclk) disable iff (!hresetn)
      (!cg.stop_all && cg.div_fields[2:0] == 3'h0) [*2]
      |=> cg.div_tick[0] && $past(cg.div_tick[0]))
      else $error("undivided field does not tick every cycle");
   a_stop_all: assert property (@(posedge hclk) disable iff (!hresetn)
      cg.stop_all |=> (cg.mod_clk_en == '0) && (cg.div_tick == '0))
      else $error("module clocks run while all stopped");

endmodule

// ### core/pdm_ctrl.sv
`timescale 1ns/1ps
// ============================================================
module pdm_ctrl (
   // AHB-Lite slave
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Core and system events
   input  wire logic        halt_exec,
   input  wire logic        irq_wake,
   input  wire logic        dma_addr_err,
   input  wire logic        nmi_wake,
   input  wire logic        watchdog_run_enable,
   input  wire logic [2:0]  clock_mode,
   // Pins
   input  wire logic        hard_standby_n,
   input  wire logic        chip_clear_n,
   // Power state
   output logic [1:0]       power_mode,
   output logic             cpu_halt,
   output logic             clock_unit_stop,
   output logic             self_refresh,
   output logic             refresh_run,
   output logic             ctrl_pin_oe_n,
   output logic             ctrl_pin_hold,
   // Module clocks
   output logic [31:0]      module_clk_en,
   output logic [19:0]      module_div_tick
);

   // ============================================================
   // Address decode: {hit, select}
   function automatic logic [3:0] decode_addr(input logic [31:0] addr);
      logic [3:0] res;
      res = '0;
      if (addr[31:2] == pdm_pkg::IDX_STBY[29:0]) begin
         res = {1'b1, pdm_pkg::SEL_STBY};
      end else begin
         for (int i = 0; i < pdm_pkg::N_REG16; i++) begin
            if (addr[31:2] == pdm_pkg::REG16_IDX[i][29:0]) begin
               res = {1'b1, 3'(i)};
            end
         end
      end
      return res;
   endfunction

   // ============================================================
   // Declarations
   logic [3:0]               ap_dec;
   logic                     ap_take;
   logic                     wr_pend_reg;
   logic                     rd_pend_reg;
   logic                     rd_done_reg;
   logic [3:0]               sel_reg;
   logic [31:0]              hrdata_reg;
   logic [31:0]              rd_word;
   logic                     wr_fire;
   logic                     wr_stby;
   logic                     wr16;
   logic [2:0]               idx;
   logic                     sby_reg;
   logic                     hiz_reg;
   logic                     sby_next;
   logic                     hiz_next;
   logic [7:0]               stby_rd;
   logic [15:0]              reg16 [0:pdm_pkg::N_REG16-1];
   logic [15:0]              wr16_val;
   logic                     init_reg;
   logic                     fast_mode;
   logic [15:0]              div_init;
   logic [15:0]              div5_init;
   pdm_pkg::pdm_state_t      state_reg;
   pdm_pkg::pdm_state_t      state_next;
   logic                     float_reg;
   logic                     float_next;
   logic                     in_sw;
   logic                     in_hw;

   // ============================================================
   // Bus phase tracking
   assign ap_dec  = decode_addr(haddr);
   assign ap_take = hsel & hready & htrans[1];

   // Address phase capture; reads take one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         rd_done_reg <= 1'b0;
         sel_reg     <= '0;
      end else if (hready) begin
         wr_pend_reg <= ap_take & hwrite & (hsize == pdm_pkg::HSIZE_WORD);
         rd_pend_reg <= ap_take & ~hwrite;
         rd_done_reg <= 1'b0;
         sel_reg     <= ap_dec;
      end else if (rd_pend_reg) begin
         rd_done_reg <= 1'b1;
      end
   end

   // Read data register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= '0;
      end else if (rd_pend_reg && !rd_done_reg) begin
         hrdata_reg <= rd_word;
      end
   end

   // Handshake and read mux
   assign idx       = sel_reg[2:0];
   assign hreadyout = ~(rd_pend_reg & ~rd_done_reg);
   assign hresp     = pdm_pkg::HRESP_OKAY;
   assign hrdata    = hrdata_reg;
   assign rd_word   = !sel_reg[3] ? 32'h0000_0000 :
                      (idx == pdm_pkg::SEL_STBY) ? {24'h00_0000, stby_rd} :
                      {16'h0000, reg16[idx]};

   // Write strobes
   assign wr_fire = wr_pend_reg & hready;
   assign wr_stby = wr_fire & sel_reg[3] & (idx == pdm_pkg::SEL_STBY);
   assign wr16    = wr_fire & sel_reg[3] & (idx != pdm_pkg::SEL_STBY);

   // ============================================================
   // Standby control register
   // standby-select and float-select interlock
   assign sby_next = (watchdog_run_enable & hwdata[pdm_pkg::SBY_BIT]) ?
                     sby_reg : hwdata[pdm_pkg::SBY_BIT];
   assign hiz_next = (watchdog_run_enable & hwdata[pdm_pkg::HIZ_BIT]) ?
                     hiz_reg : hwdata[pdm_pkg::HIZ_BIT];
   assign stby_rd  = {sby_reg, hiz_reg, pdm_pkg::STBY_FIXED};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sby_reg <= pdm_pkg::STBY_RST[pdm_pkg::SBY_BIT];
         hiz_reg <= pdm_pkg::STBY_RST[pdm_pkg::HIZ_BIT];
      end else if (wr_stby) begin
         sby_reg <= sby_next;
         hiz_reg <= hiz_next;
      end
   end

   // ============================================================
   // Halt and divider registers
   assign fast_mode = pdm_pkg::FAST_MODES[clock_mode];
   assign div_init  = fast_mode ? pdm_pkg::DIV_FAST : pdm_pkg::DIV_SLOW;
   assign div5_init = fast_mode ? pdm_pkg::DIV5_FAST : pdm_pkg::DIV_SLOW;
   assign wr16_val  = (idx < 3'(pdm_pkg::N_HALT)) ? hwdata[15:0] :
                      (hwdata[15:0] | pdm_pkg::DIV_RO);

   // halt regs clear; mode strap loaded after release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         init_reg <= 1'b0;
         for (int i = 0; i < pdm_pkg::N_REG16; i++) begin
            reg16[i] <= (i < pdm_pkg::N_HALT) ? pdm_pkg::HALT_RST : pdm_pkg::DIV_SLOW;
         end
      end else if (!init_reg) begin
         init_reg <= 1'b1;
         for (int i = pdm_pkg::N_HALT; i < pdm_pkg::N_REG16; i++) begin
            reg16[i] <= (i == pdm_pkg::DIV5_POS) ? div5_init : div_init;
         end
      end else if (wr16) begin
         reg16[idx] <= wr16_val;
      end
   end

   // ============================================================
   // Power state machine
   always_comb begin
      state_next = state_reg;
      float_next = float_reg;
      if (!hard_standby_n) begin
         state_next = pdm_pkg::PDM_HW_STBY;
      end else begin
         case (state_reg)
            pdm_pkg::PDM_RUN: begin
               if (halt_exec && sby_reg) begin
                  state_next = pdm_pkg::PDM_SW_STBY;
                  float_next = hiz_reg;
               end else if (halt_exec) begin
                  state_next = pdm_pkg::PDM_SLEEP;
               end
            end
            pdm_pkg::PDM_SLEEP: begin
               if (irq_wake || dma_addr_err) begin
                  state_next = pdm_pkg::PDM_RUN;
               end
            end
            pdm_pkg::PDM_SW_STBY: begin
               if (nmi_wake) begin
                  state_next = pdm_pkg::PDM_RUN;
               end
            end
            default: begin
               // leave only with clear pin low
               if (!chip_clear_n) begin
                  state_next = pdm_pkg::PDM_RUN;
               end
            end
         endcase
      end
   end

   // State registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= pdm_pkg::PDM_RUN;
         float_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         float_reg <= float_next;
      end
   end

   // ============================================================
   // Power state outputs
   assign in_sw           = (state_reg == pdm_pkg::PDM_SW_STBY);
   assign in_hw           = (state_reg == pdm_pkg::PDM_HW_STBY);
   assign power_mode      = state_reg;
   assign cpu_halt        = (state_reg != pdm_pkg::PDM_RUN);
   assign clock_unit_stop = in_sw | in_hw;
   assign self_refresh    = in_sw;
   assign refresh_run     = ~(in_sw | in_hw);
   assign ctrl_pin_oe_n   = in_hw | (in_sw & float_reg);
   assign ctrl_pin_hold   = in_sw & ~float_reg;

   // ============================================================
   // Module clock gating
   pdm_clk_if cg ();

   assign cg.halt_bits = {reg16[1], reg16[0]};
   assign cg.stop_all  = clock_unit_stop;

   for (genvar j = 0; j < pdm_pkg::N_FIELDS; j++) begin : g_field
      assign cg.div_fields[j*pdm_pkg::FIELD_W +: pdm_pkg::FIELD_W] =
         reg16[pdm_pkg::N_HALT + j/pdm_pkg::NIB_PER]
              [(j%pdm_pkg::NIB_PER)*pdm_pkg::NIB_W +: pdm_pkg::FIELD_W];
   end

   pdm_clk_gate u_gate (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cg      (cg.gate)
   );

   assign module_clk_en   = cg.mod_clk_en;
   assign module_div_tick = cg.div_tick;

   // ============================================================
   // Checks
   a_sleep_entry: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == pdm_pkg::PDM_RUN && halt_exec && !sby_reg && hard_standby_n)
      |=> state_reg == pdm_pkg::PDM_SLEEP && cpu_halt && refresh_run)
      else $error("sleep not entered");
   a_sleep_exit: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == pdm_pkg::PDM_SLEEP && irq_wake && hard_standby_n)
      |=> state_reg == pdm_pkg::PDM_RUN)
      else $error("sleep not left on interrupt");
   a_swstby_entry: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == pdm_pkg::PDM_RUN && halt_exec && sby_reg && hard_standby_n)
      |=> clock_unit_stop && self_refresh && !refresh_run)
      else $error("software standby not entered");
   a_hwstby_entry: assert property (@(posedge hclk) disable iff (!hresetn)
      !hard_standby_n |=> in_hw && ctrl_pin_oe_n && !refresh_run)
      else $error("hardware standby not entered");
   a_hwstby_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      (in_hw && chip_clear_n) |=> in_hw)
      else $error("hardware standby left without clear pin");
   a_sby_lock: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_stby && watchdog_run_enable && !sby_reg) |=> !sby_reg)
      else $error("standby-select set while watchdog runs");
   a_pin_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      (in_sw && !float_reg) |-> !ctrl_pin_oe_n && ctrl_pin_hold)
      else $error("pins not held in standby");
   a_pin_float: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == pdm_pkg::PDM_RUN && halt_exec && sby_reg && hiz_reg && hard_standby_n)
      |=> in_sw && ctrl_pin_oe_n)
      else $error("pins not floated in standby");
   a_hiz_lock: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_stby && watchdog_run_enable && !hiz_reg) |=> !hiz_reg)
      else $error("float-select set while watchdog runs");
   a_rsv_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_done_reg && rd_pend_reg && sel_reg == {1'b1, pdm_pkg::SEL_STBY}) |-> !hrdata[5])
      else $error("bit 5 reads one");
   a_rsv_ones: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_done_reg && rd_pend_reg && sel_reg == {1'b1, pdm_pkg::SEL_STBY})
      |-> hrdata[4:0] == 5'h1F && hrdata[31:8] == '0)
      else $error("bits 4..0 do not read one");
   a_stby_keep: assert property (@(posedge hclk) disable iff (!hresetn)
      (in_sw && !wr_stby) |=> $stable(stby_rd))
      else $error("control changed in standby");
   a_stby_reset: assert property (@(posedge hclk) disable iff (!hresetn)
      !init_reg |-> stby_rd == pdm_pkg::STBY_RST)
      else $error("control reset value wrong");
   a_div_init: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(init_reg) |-> reg16[2] == $past(div_init) && reg16[5] == $past(div_init))
      else $error("divider 1-4 reset value wrong");
   a_div5_init: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(init_reg) |-> reg16[pdm_pkg::DIV5_POS] == $past(div5_init))
      else $error("divider 5 reset value wrong");
   a_halt_reset: assert property (@(posedge hclk) disable iff (!hresetn)
      !init_reg |-> reg16[0] == pdm_pkg::HALT_RST && reg16[1] == pdm_pkg::HALT_RST)
      else $error("halt registers not cleared");
   a_halt_keep: assert property (@(posedge hclk) disable iff (!hresetn)
      (in_sw && !wr16) |=> $stable(reg16[0]) && $stable(reg16[1]))
      else $error("halt registers changed in standby");
   a_float_keep: assert property (@(posedge hclk) disable iff (!hresetn)
      (in_sw && state_next == pdm_pkg::PDM_SW_STBY) |=> $stable(float_reg))
      else $error("float choice changed after entry");

endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ps
// ============================================================
// Power-down control bench
module tb_top;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic        halt_exec, irq_wake, dma_addr_err, nmi_wake, watchdog_run_enable;
   logic        hard_standby_n, chip_clear_n, cpu_halt, clock_unit_stop, self_refresh;
   logic        refresh_run, ctrl_pin_oe_n, ctrl_pin_hold;
   logic [31:0] haddr, hwdata, hrdata, rv, module_clk_en;
   logic [1:0]  htrans, power_mode;
   logic [2:0]  hsize, clock_mode;
   logic [19:0] module_div_tick;
   logic [15:0] h1, h2, dv;
   int          err_total, total_checks, cyc;

   // Device under test, one slave so hready follows hreadyout
   pdm_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .halt_exec(halt_exec), .irq_wake(irq_wake), .dma_addr_err(dma_addr_err),
      .nmi_wake(nmi_wake), .watchdog_run_enable(watchdog_run_enable),
      .clock_mode(clock_mode), .hard_standby_n(hard_standby_n),
      .chip_clear_n(chip_clear_n), .power_mode(power_mode), .cpu_halt(cpu_halt),
      .clock_unit_stop(clock_unit_stop), .self_refresh(self_refresh),
      .refresh_run(refresh_run), .ctrl_pin_oe_n(ctrl_pin_oe_n),
      .ctrl_pin_hold(ctrl_pin_hold), .module_clk_en(module_clk_en),
      .module_div_tick(module_div_tick));

   // ============================================================
   // Expectations
   function automatic logic [31:0] adr(input logic [31:0] idx);
      return {idx[29:0], 2'b00};
   endfunction
   function automatic logic [15:0] div_rst(input int m, input int k);
      logic fast;
      fast = (m == 1) || (m == 3) || (m == 5) || (m == 6);
      if (k == 4) return fast ? 16'hCCCC : 16'hFFFF;
      return fast ? 16'h8888 : 16'hFFFF;
   endfunction
   // Mode, cpu halt, clock stop, self refresh, refresh, float, hold
   function automatic logic [7:0] pwr(input int m, input logic hz);
      case (m)
         0:       return 8'h04;
         1:       return 8'h64;
         2:       return {6'h2E, hz, ~hz};
         default: return 8'hF2;
      endcase
   endfunction

   // ============================================================
   // Bus and check tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [31:0] idx, input logic [31:0] d);
      haddr <= adr(idx);
      htrans <= 2'h2;
      hwrite <= 1'b1;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task automatic rd(input logic [31:0] idx, output logic [31:0] d);
      haddr <= adr(idx);
      htrans <= 2'h2;
      hwrite <= 1'b0;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask
   task automatic pulse(input int w);
      case (w)
         0:       halt_exec <= 1'b1;
         1:       irq_wake <= 1'b1;
         2:       dma_addr_err <= 1'b1;
         default: nmi_wake <= 1'b1;
      endcase
      @(posedge hclk);
      {halt_exec, irq_wake, dma_addr_err, nmi_wake} <= 4'h0;
      repeat (3) @(posedge hclk);
   endtask
   task automatic chk_pwr(input int m, input logic hz);
      chk("power", pwr(m, hz), {power_mode, cpu_halt, clock_unit_stop, self_refresh,
          refresh_run, ctrl_pin_oe_n, ctrl_pin_hold});
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ============================================================
   // Clock and timeout
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         test_done();
      end
   end

   // ============================================================
   // Main sequence
   initial begin
      {hresetn, hsel, hwrite, halt_exec, irq_wake, dma_addr_err, nmi_wake} = 7'h20;
      {watchdog_run_enable, hard_standby_n, chip_clear_n} = 3'h3;
      {haddr, hwdata, htrans, hsize, clock_mode} = {64'h0, 2'h0, 3'h2, 3'h0};
      {err_total, total_checks} = '0;
      void'($urandom(32'hca347ae5));
      // reset values for every clock mode
      for (int m = 0; m < 8; m++) begin
         hresetn <= 1'b0;
         clock_mode <= 3'(m);
         repeat (20) @(posedge hclk);
         hresetn <= 1'b1;
         repeat (2) @(posedge hclk);
         rd(pdm_pkg::IDX_STBY, rv); chk("stby_rst", 32'h1F, rv);
         for (int k = 0; k < 7; k++) begin
            rd(pdm_pkg::REG16_IDX[k], rv);
            chk("reg16_rst", (k < 2) ? 32'h0 : {16'h0, div_rst(m, k - 2)}, rv);
         end
      end
      wr(32'h0000_0100, 32'hFFFF_FFFF);
      rd(32'h0000_0100, rv); chk("unmapped", 32'h0, rv);
      chk("hresp", 32'h0, {31'h0, hresp});
      wr(pdm_pkg::IDX_STBY, 32'h60); rd(pdm_pkg::IDX_STBY, rv); chk("stby", 32'h5F, rv);
      watchdog_run_enable <= 1'b1;
      wr(pdm_pkg::IDX_STBY, 32'hC0); rd(pdm_pkg::IDX_STBY, rv); chk("stby", 32'h5F, rv);
      wr(pdm_pkg::IDX_STBY, 32'h00); rd(pdm_pkg::IDX_STBY, rv); chk("stby", 32'h1F, rv);
      wr(pdm_pkg::IDX_STBY, 32'h40); rd(pdm_pkg::IDX_STBY, rv); chk("stby", 32'h1F, rv);
      watchdog_run_enable <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         h1 = 16'($urandom);
         h2 = (i == 0) ? 16'hFFFF : 16'($urandom);
         wr(pdm_pkg::REG16_IDX[0], {16'h0, h1});
         wr(pdm_pkg::REG16_IDX[1], {16'h0, h2});
         rd(pdm_pkg::REG16_IDX[1], rv); chk("halt2", {16'h0, h2}, rv);
         chk("clk_en", ~{h2, h1}, module_clk_en);
      end
      for (int k = 2; k < 7; k++) begin
         dv = 16'($urandom);
         wr(pdm_pkg::REG16_IDX[k], {16'h0, dv});
         rd(pdm_pkg::REG16_IDX[k], rv); chk("div", {16'h0, dv | 16'h8888}, rv);
         wr(pdm_pkg::REG16_IDX[k], 32'h8888);
      end
      repeat (3) @(posedge hclk);
      chk("ticks", 32'hFFFFF, {12'h0, module_div_tick});
      for (int w = 1; w < 3; w++) begin
         wr(pdm_pkg::IDX_STBY, 32'h00);
         pulse(0); chk_pwr(1, 1'b0);
         pulse(w); chk_pwr(0, 1'b0);
      end
      for (int hz = 0; hz < 2; hz++) begin
         wr(pdm_pkg::IDX_STBY, {24'h0, 1'b1, 1'(hz), 6'h1F});
         pulse(0); chk_pwr(2, 1'(hz));
         chk("clk_en_sby", 32'h0, module_clk_en);
         chk("ticks_sby", 32'h0, {12'h0, module_div_tick});
         rd(pdm_pkg::IDX_STBY, rv); chk("stby_kept", {24'h0, 1'b1, 1'(hz), 6'h1F}, rv);
         wr(pdm_pkg::IDX_STBY, {24'h0, 1'b1, 1'(1 - hz), 6'h1F});
         pulse(1); chk_pwr(2, 1'(hz));
         pulse(3); chk_pwr(0, 1'b0);
         rd(pdm_pkg::REG16_IDX[0], rv); chk("halt_kept", {16'h0, h1}, rv);
      end
      // hardware standby entry and exit under clear pin
      hard_standby_n <= 1'b0;
      repeat (3) @(posedge hclk);
      chk_pwr(3, 1'b1);
      hard_standby_n <= 1'b1;
      repeat (3) @(posedge hclk);
      chk_pwr(3, 1'b1);
      chip_clear_n <= 1'b0;
      repeat (3) @(posedge hclk);
      chk_pwr(0, 1'b0);
      chip_clear_n <= 1'b1;
      test_done();
   end
endmodule
